//--- include/flags_defs.svh
`ifndef FLAGS_DEFS_SVH
`define FLAGS_DEFS_SVH
`define FLG_BIT_BANK      3
`define FLG_BIT_IMASK     6
`define FLG_BIT_RSVD      11
`define FLG_BIT_STK       7
`define FLG_IPL_LSB       12
`define FLG_IPL_MSB       14
`define FLG_RESET         16'h0000
`define OFF_FLAGS         12'h000
`define OFF_SAVED         12'h004
`define OFF_REQ           12'h008
`define OFF_STATUS        12'h00C
`define OFF_TRAP          12'h010
`define OFF_RET           12'h014
`define OFF_BANKREG       12'h020
`define OFF_BANKEND       12'h058
`define SOFT_VEC_LAST     6'h1F
`endif

//--- include/flags_pkg.sv
package flags_pkg;
  typedef logic [2:0]  level_t;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ACK, ST_RUN} phase_t;
endpackage : flags_pkg

//--- hdl/cpu_interrupt_accept_flags.sv
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "flags_defs.svh"
// Function
// - the core holds eighteen 16-bit registers, with two copies of a seven-register bank; here the 14 bank words form one array and the bank flag selects none.
// - maskable interrupts are blocked while the mask flag is 0 and allowed while 1.
// - the mask flag clears when an interrupt is acknowledged.
// - stack select 0 picks the interrupt stack, 1 picks the user stack.
// - stack select clears on a hardware interrupt or a trap with vector 0 to 31.
// - the priority level is a three-bit field for levels 0 to 7.
// - a request is enabled only if its priority is above the current level.
// - the reserved bit is written as 0 and reads back undefined, here zero.
module cpu_interrupt_accept_flags
#(
  parameter int WIDTH = 16
)(
  // clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // apb slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // interrupt request side
  input  wire logic            irq_req,
  input  wire flags_pkg::level_t irq_level,
  input  wire logic            insn_boundary,
  output logic                 irq_ack,
  // stack and bank selection
  output logic                 use_user_stack,
  output logic                 bank_sel
);
  import flags_pkg::*;

  // refuse any data width other than the 16-bit flag word
  if (WIDTH != 16)
  begin : g_width_check
    $error("only 16-bit data is supported");
  end

  typedef struct packed {
    word_t        flags;
    word_t        saved;
    word_t [13:0] bank;
    word_t        interrupt_stack_pointer;
    word_t        user_stack_pointer;
    logic  [31:0] rdata;
    logic         ack;
    logic         had_ack;
  } state_t;

  state_t cur;
  state_t next_cur;

  logic      wr;
  logic      rd;
  logic      accept;
  logic      mask_on;
  level_t    processor_priority_level;
  logic      mapped;
  logic [3:0] bidx;
  word_t     wdata;

  assign wr     = psel && penable && pwrite;
  // read data is captured in the setup cycle and leaves a flop in access
  assign rd     = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign wdata  = pwdata[15:0];
  assign mask_on = cur.flags[`FLG_BIT_IMASK];
  assign processor_priority_level    = cur.flags[`FLG_IPL_MSB:`FLG_IPL_LSB];
  // mask and priority judged together at a boundary
  assign accept = irq_req && insn_boundary && mask_on
                  && (irq_level > processor_priority_level);
  assign bidx   = paddr[5:2] - 4'h8;
  assign mapped = (paddr[1:0] == 2'b00) &&
                  (paddr <= `OFF_RET || (paddr >= `OFF_BANKREG &&
                   paddr < `OFF_BANKEND));
  assign pslverr = psel && penable && !mapped;

  always_comb
  begin
    next_cur = cur;
    next_cur.ack = 1'b0;
    if (wr && paddr == `OFF_FLAGS)
    begin
      next_cur.flags = wdata;
      next_cur.flags[`FLG_BIT_RSVD] = 1'b0;
    end
    if (wr && paddr == `OFF_RET)
      next_cur.flags = cur.saved;
    if (wr && paddr >= `OFF_BANKREG && paddr < `OFF_BANKEND
        && paddr[1:0] == 2'b00)
      // bank word chosen by address bits 5:2 alone, 14 words in one array; the bank flag plays no part
      next_cur.bank[bidx] = wdata;
    if (wr && paddr == `OFF_TRAP && pwdata[5:0] <= `SOFT_VEC_LAST)
    begin
      next_cur.saved = cur.flags;
      next_cur.flags[`FLG_BIT_STK] = 1'b0;
    end
    if (accept)
    begin
      next_cur.saved = cur.flags;
      next_cur.flags[`FLG_BIT_IMASK] = 1'b0;
      next_cur.flags[`FLG_BIT_STK] = 1'b0;
      next_cur.ack = 1'b1;
      next_cur.had_ack = 1'b1;
    end
    next_cur.rdata = 32'h0000_0000;
    if (rd)
    begin
      unique case (paddr)
        `OFF_FLAGS:  next_cur.rdata = {16'h0000, cur.flags};
        `OFF_SAVED:  next_cur.rdata = {16'h0000, cur.saved};
        `OFF_STATUS: next_cur.rdata = {29'h0, cur.had_ack, processor_priority_level > 3'h0,
                                       mask_on};
        default:
          if (paddr >= `OFF_BANKREG && paddr < `OFF_BANKEND)
            next_cur.rdata = {16'h0000, cur.bank[bidx]};
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur <= '0;
      cur.flags <= `FLG_RESET;
    end
    else
      cur <= next_cur;
  end

  // rdata is zero outside the access phase of a read
  assign prdata = cur.rdata;
  assign irq_ack = cur.ack;
  assign use_user_stack = cur.flags[`FLG_BIT_STK];
  assign bank_sel = cur.flags[`FLG_BIT_BANK];

  // named steps that the properties below use, some in several
  sequence accept_s;
    accept;
  endsequence : accept_s

  sequence entered_s;
    irq_ack && !mask_on && !use_user_stack;
  endsequence : entered_s

  sequence flag_wr_s;
    wr && paddr == `OFF_FLAGS && !accept;
  endsequence : flag_wr_s

  sequence trap_low_s;
    wr && paddr == `OFF_TRAP && pwdata[5:0] <= `SOFT_VEC_LAST;
  endsequence : trap_low_s

  sequence trap_high_s;
    wr && paddr == `OFF_TRAP && pwdata[5:0] > `SOFT_VEC_LAST && !accept;
  endsequence : trap_high_s

  sequence ret_s;
    wr && paddr == `OFF_RET && !accept;
  endsequence : ret_s

  sequence bank_wr_s;
    wr && paddr >= `OFF_BANKREG && paddr < `OFF_BANKEND
    && paddr[1:0] == 2'b00;
  endsequence : bank_wr_s

  ack_clears_mask_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    accept_s |=> !cur.flags[`FLG_BIT_IMASK] && irq_ack)
    else $error("mask flag not cleared on ack");
  no_ack_masked_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !mask_on |=> !irq_ack)
    else $error("ack while masked");
  prio_gate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (irq_req && irq_level <= processor_priority_level) |=> !irq_ack)
    else $error("ack at equal or lower level");
  stack_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    accept_s |=> !use_user_stack)
    else $error("stack select not cleared");
  save_flags_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    accept_s |=> cur.saved == $past(cur.flags))
    else $error("flags not saved");
  boundary_only_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !insn_boundary |=> !irq_ack)
    else $error("ack off boundary");
  rsvd_zero_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    flag_wr_s |=> !cur.flags[`FLG_BIT_RSVD])
    else $error("reserved bit set");
  stack_sel_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    flag_wr_s |=> use_user_stack == $past(pwdata[`FLG_BIT_STK]))
    else $error("stack select not written");
  entry_seq_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    accept_s |=> entered_s)
    else $error("interrupt entry incomplete");
  ack_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_ack |=> !irq_ack)
    else $error("ack longer than one cycle");
  trap_low_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    trap_low_s |=> !use_user_stack)
    else $error("low trap kept user stack");
  trap_high_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    trap_high_s |=> $stable(use_user_stack))
    else $error("high trap changed stack select");
  ret_restore_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ret_s |=> cur.flags == $past(cur.saved))
    else $error("flags not restored");
  level_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    flag_wr_s |=> processor_priority_level == $past(pwdata[`FLG_IPL_MSB:`FLG_IPL_LSB]))
    else $error("priority level not written");
  mask_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    flag_wr_s |=> mask_on == $past(pwdata[`FLG_BIT_IMASK]))
    else $error("mask flag not written");
  bank_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    bank_wr_s |=> cur.bank[$past(bidx)] == $past(wdata))
    else $error("bank word not written");
endmodule : cpu_interrupt_accept_flags

//--- sim/irq_source.sv
`timescale 1ns/1ps
module irq_source
  import flags_pkg::*;
(
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   fire,
  input  wire logic   drop,
  input  wire level_t lvl,
  input  wire logic   irq_ack,
  output logic        irq_req,
  output level_t      irq_level
);
  // holds a request until taken or withdrawn, then scrambles the level
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      irq_req   <= 1'b0;
      irq_level <= 3'h0;
    end
    else if (fire)
    begin
      irq_req   <= 1'b1;
      irq_level <= lvl;
    end
    else if (irq_ack || drop)
    begin
      irq_req   <= 1'b0;
      irq_level <= ~irq_level;
    end
endmodule : irq_source

//--- sim/cpu_interrupt_accept_flags_tb.sv
`timescale 1ns/1ps
`include "flags_defs.svh"
module cpu_interrupt_accept_flags_tb;
  import flags_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic insn_boundary = 0, fire = 0, drop = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq_req, irq_ack, use_user_stack, bank_sel;
  level_t irq_level, lvl = 3'h0;
  logic [16:0] exp_q[$];
  logic [15:0] v;
  int mismatches = 0, compares = 0;
  always #50 pclk = ~pclk;
  always @(posedge pclk) insn_boundary <= $urandom;
  cpu_interrupt_accept_flags DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_req(irq_req), .irq_level(irq_level), .insn_boundary(insn_boundary),
    .irq_ack(irq_ack), .use_user_stack(use_user_stack), .bank_sel(bank_sel));
  irq_source SRC (.pclk(pclk), .presetn(presetn), .fire(fire), .drop(drop),
    .lvl(lvl), .irq_ack(irq_ack), .irq_req(irq_req), .irq_level(irq_level));
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  task automatic check(string n, logic [16:0] e, logic [16:0] s);
    compares++;
    if (s !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic apb(logic w, logic [11:0] a, logic [15:0] d,
                     logic [16:0] e = 17'h0);
    int i;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {16'h0, d};
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin mismatches++; complete_run; end
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // read results leave the queue as the access phase completes
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size())
      check("read", exp_q.pop_front(), {pslverr, prdata[15:0]});
  task automatic irq(level_t l, logic e);
    logic seen;
    @(posedge pclk); fire <= 1'b1; lvl <= l;
    @(posedge pclk); fire <= 1'b0;
    seen = 0;
    for (int i = 0; i < 40 && !seen; i++)
    begin @(posedge pclk); seen = (irq_ack === 1'b1); end
    check("ack", {16'h0, e}, {16'h0, seen});
    @(posedge pclk); drop <= 1'b1;
    @(posedge pclk); drop <= 1'b0;
  endtask : irq
  initial
  begin
    void'($urandom(32'hD033));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `OFF_FLAGS, 16'h0, 17'h0);
    irq(3'h5, 1'b0);
    apb(1, `OFF_FLAGS, 16'h30C8);
    apb(0, `OFF_FLAGS, 16'h0, 17'h30C8);
    @(posedge pclk);
    check("sel", {15'h0, use_user_stack, bank_sel}, 17'h3);
    irq(3'h3, 1'b0);
    irq(3'h4, 1'b1);
    apb(0, `OFF_FLAGS, 16'h0, 17'h3008);
    apb(0, `OFF_SAVED, 16'h0, 17'h30C8);
    apb(0, `OFF_STATUS, 16'h0, 17'h00006);
    check("stack", {16'h0, use_user_stack}, 17'h0);
    for (int t = 0; t < 2; t++)
    begin
      apb(1, `OFF_FLAGS, 16'h3080);
      apb(1, `OFF_TRAP, 16'($urandom % 32) + 16'(t * 32));
      apb(0, `OFF_FLAGS, 16'h0, t ? 17'h3080 : 17'h3000);
    end
    apb(1, `OFF_RET, 16'h0);
    apb(0, `OFF_FLAGS, 16'h0, 17'h3080);
    v = 16'($urandom);
    v[`FLG_BIT_RSVD] = 1'b0;
    apb(1, `OFF_FLAGS, v);
    apb(0, `OFF_FLAGS, 16'h0, {1'b0, v});
    v = 16'($urandom);
    apb(1, `OFF_BANKREG, v);
    apb(1, 12'h054, ~v);
    apb(0, `OFF_BANKREG, 16'h0, {1'b0, v});
    apb(0, 12'h054, 16'h0, {1'b0, ~v});
    apb(0, 12'h058, 16'h0, 17'h10000);
    complete_run;
  end
endmodule : cpu_interrupt_accept_flags_tb
